// ---- hdl/chip_select_pkg.sv ----
package chip_select_pkg;
  localparam int          ADDR_W          = 20;
  localparam int          NUM_MID         = 4;
  localparam int          NUM_PERIPH      = 7;
  localparam int          NUM_PERIPH_LOW  = 5;
  localparam logic [19:0] UPPER_RST_START = 20'hffc00;
  localparam logic [19:0] UPPER_RST_END   = 20'hfffff;
  localparam logic [7:0]  NUMERICS_VECTOR = 8'h10;
  // register map for the programming port
  localparam logic [3:0]  REG_UPPER_START = 4'h0;
  localparam logic [3:0]  REG_UPPER_END   = 4'h1;
  localparam logic [3:0]  REG_LOWER_START = 4'h2;
  localparam logic [3:0]  REG_LOWER_END   = 4'h3;
  localparam logic [3:0]  REG_MID_START   = 4'h4;
  localparam logic [3:0]  REG_MID_END     = 4'h5;
  localparam logic [3:0]  REG_PER_START   = 4'h6;
  localparam logic [3:0]  REG_PER_END     = 4'h7;
  localparam logic [3:0]  REG_CONTROL     = 4'h8;
  localparam logic [3:0]  REG_STATUS      = 4'h9;
  localparam logic [3:0]  REG_MASK        = 4'ha;
  // control register bits
  localparam int          CTL_UPPER_EN    = 0;
  localparam int          CTL_LOWER_EN    = 1;
  localparam int          CTL_MID_EN      = 2;
  localparam int          CTL_PER_EN      = 3;
  localparam int          CTL_NUMERICS    = 4;
  localparam int          CTL_ADDR_OUT    = 5;
  localparam int          CTL_UPPER_IO    = 6;
  localparam int          CTL_PER_IO      = 7;
  localparam int          CTL_W           = 8;
  localparam logic [7:0]  CTL_RESET       = 8'h01;
  // status bits: numerics error, transfer request seen
  localparam int          STS_ERROR       = 0;
  localparam int          STS_REQUEST     = 1;
  localparam int          STS_W           = 2;
endpackage : chip_select_pkg

// ---- hdl/chip_select_unit.sv ----
`timescale 1ns/1ps
// Functional notes
// R1: mid-range selects follow memory cycles in range
// R2: mid-range pins decode only when enabled
// R3: numerics mode turns three mid pins handshake
// R4: request input marks pending coprocessor transfer
// R5: error sampled at numerics start raises type 16
// R6: coprocessor select on numerics accesses
// R7: five low peripheral selects on mem/io range
// R8: sixth/seventh peripheral selects on range
// R9: optionally drive latched address bits 2:1
// R10: upper select reset range; lower inactive
// R11: upper mem and io; lower memory only
// R12: selects active low, high in hold/reset/powerdown
// R13: decode each bus cycle, hold through cycle
module chip_select_unit
  import chip_select_pkg::*;
#(
  parameter int ADDR_WIDTH = ADDR_W
) (
  // clock and reset
  input  wire logic                  ref_clk_i,
  input  wire logic                  rst_i,
  // bus cycle from the core
  input  wire logic                  cycle_start_i,
  input  wire logic                  cycle_end_i,
  input  wire logic [ADDR_WIDTH-1:0] cycle_addr_i,
  input  wire logic                  cycle_io_i,
  input  wire logic                  cycle_numerics_i,
  input  wire logic                  numerics_op_start_i,
  input  wire logic                  bus_granted_i,
  input  wire logic                  powerdown_i,
  // register port
  input  wire logic [3:0]            reg_addr_i,
  input  wire logic [19:0]           reg_wdata_i,
  input  wire logic                  reg_write_i,
  input  wire logic                  reg_read_i,
  output logic      [19:0]           reg_rdata_o,
  // coprocessor pins
  input  wire logic                  coproc_transfer_request_i,
  input  wire logic                  coproc_error_i,
  output logic                       coproc_select_n_o,
  output logic                       coproc_request_o,
  output logic                       numerics_trap_o,
  output logic      [7:0]            numerics_vector_o,
  // select pins
  output logic                       upper_region_select_n_o,
  output logic                       lower_region_select_n_o,
  output logic      [NUM_MID-1:0]    mid_range_select_n_o,
  output logic      [NUM_MID-1:0]    mid_range_select_oe_o,
  output logic      [NUM_PERIPH-1:0] peripheral_select_n_o,
  // interrupt
  output logic                       irq_o
);

  function automatic logic in_range(input logic [ADDR_WIDTH-1:0] a,
                                    input logic [19:0] lo,
                                    input logic [19:0] hi);
    in_range = (20'(a) >= lo) && (20'(a) <= hi);
  endfunction : in_range

  // block idx of a range split into equal spans; shared by both select banks
  function automatic logic in_block(input logic [ADDR_WIDTH-1:0] a,
                                    input logic [19:0]           base,
                                    input logic [19:0]           span,
                                    input int                    idx);
    in_block = in_range(a, 20'(base + 20'(idx) * span),
                        20'(base + 20'(idx + 1) * span - 20'h00001));
  endfunction : in_block

  logic [19:0]       upper_start, upper_end, lower_start, lower_end;
  logic [19:0]       mid_start, mid_end, per_start, per_end;
  logic [CTL_W-1:0]  control;
  logic [STS_W-1:0]  status, mask;
  logic [19:0]       next_upper_start, next_upper_end, next_lower_start, next_lower_end;
  logic [19:0]       next_mid_start, next_mid_end, next_per_start, next_per_end;
  logic [CTL_W-1:0]  next_control;
  logic [STS_W-1:0]  next_status, next_mask;
  logic [19:0]       next_rdata;

  // pin synchronisers
  logic [1:0] req_sync, err_sync;
  logic       req_prev;

  // register file
  always_comb begin
    next_upper_start = upper_start;
    next_upper_end   = upper_end;
    next_lower_start = lower_start;
    next_lower_end   = lower_end;
    next_mid_start   = mid_start;
    next_mid_end     = mid_end;
    next_per_start   = per_start;
    next_per_end     = per_end;
    next_control     = control;
    next_mask        = mask;
    next_status      = status;
    if (reg_write_i) begin
      unique case (reg_addr_i)
        REG_UPPER_START: next_upper_start = reg_wdata_i;
        REG_UPPER_END:   next_upper_end   = reg_wdata_i;
        REG_LOWER_START: next_lower_start = reg_wdata_i;
        REG_LOWER_END:   next_lower_end   = reg_wdata_i;
        REG_MID_START:   next_mid_start   = reg_wdata_i;
        REG_MID_END:     next_mid_end     = reg_wdata_i;
        REG_PER_START:   next_per_start   = reg_wdata_i;
        REG_PER_END:     next_per_end     = reg_wdata_i;
        REG_CONTROL:     next_control     = reg_wdata_i[CTL_W-1:0];
        REG_STATUS:      next_status      = status & ~reg_wdata_i[STS_W-1:0];
        REG_MASK:        next_mask        = reg_wdata_i[STS_W-1:0];
        default: ;
      endcase
    end
    // set beats a same-cycle clear
    if (control[CTL_NUMERICS] && numerics_op_start_i && err_sync[1]) begin
      next_status[STS_ERROR] = 1'b1; // [R5]
    end
    if (control[CTL_NUMERICS] && req_sync[1] && !req_prev) begin
      next_status[STS_REQUEST] = 1'b1; // [R4]
    end
    next_rdata = '0;
    if (reg_read_i) begin
      unique case (reg_addr_i)
        REG_UPPER_START: next_rdata = upper_start;
        REG_UPPER_END:   next_rdata = upper_end;
        REG_LOWER_START: next_rdata = lower_start;
        REG_LOWER_END:   next_rdata = lower_end;
        REG_MID_START:   next_rdata = mid_start;
        REG_MID_END:     next_rdata = mid_end;
        REG_PER_START:   next_rdata = per_start;
        REG_PER_END:     next_rdata = per_end;
        REG_CONTROL:     next_rdata = 20'(control);
        REG_STATUS:      next_rdata = 20'(status);
        REG_MASK:        next_rdata = 20'(mask);
        default:         next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      upper_start <= UPPER_RST_START; // [R10]
      upper_end   <= UPPER_RST_END;
      lower_start <= '0;
      lower_end   <= '0;
      mid_start   <= '0;
      mid_end     <= '0;
      per_start   <= '0;
      per_end     <= '0;
      control     <= CTL_RESET;
      status      <= '0;
      mask        <= '0;
      reg_rdata_o <= '0;
      req_sync    <= '0;
      err_sync    <= '0;
      req_prev    <= 1'b0;
    end else begin
      upper_start <= next_upper_start;
      upper_end   <= next_upper_end;
      lower_start <= next_lower_start;
      lower_end   <= next_lower_end;
      mid_start   <= next_mid_start;
      mid_end     <= next_mid_end;
      per_start   <= next_per_start;
      per_end     <= next_per_end;
      control     <= next_control;
      status      <= next_status;
      mask        <= next_mask;
      reg_rdata_o <= next_rdata;
      req_sync    <= {req_sync[0], coproc_transfer_request_i};
      err_sync    <= {err_sync[0], coproc_error_i};
      req_prev    <= req_sync[1];
    end
  end

  // decode: latched at cycle start, held until cycle end
  logic                  active, next_active;
  logic                  upper_hit, lower_hit, coproc_hit, next_upper_hit, next_lower_hit, next_coproc_hit;
  logic [NUM_MID-1:0]    mid_hit, next_mid_hit;
  logic [NUM_PERIPH-1:0] per_hit, next_per_hit;
  logic [1:0]            addr_latch, next_addr_latch;
  logic                  mem_cyc, next_trap;
  logic [19:0]           mid_span, per_span;

  assign mem_cyc  = !cycle_io_i;
  // a range that is not a multiple of the bank size leaves its tail unselected
  assign mid_span = 20'((mid_end - mid_start + 20'h00001) / 20'(NUM_MID));
  assign per_span = 20'((per_end - per_start + 20'h00001) / 20'(NUM_PERIPH));

  always_comb begin
    next_active     = active;
    next_upper_hit  = upper_hit;
    next_lower_hit  = lower_hit;
    next_coproc_hit = coproc_hit;
    next_mid_hit    = mid_hit;
    next_per_hit    = per_hit;
    next_addr_latch = addr_latch;
    next_trap       = 1'b0;
    if (cycle_end_i) begin
      next_active     = 1'b0;
      next_upper_hit  = 1'b0;
      next_lower_hit  = 1'b0;
      next_coproc_hit = 1'b0;
      next_mid_hit    = '0;
      next_per_hit    = '0;
    end
    if (cycle_start_i) begin // [R13]
      next_active     = 1'b1;
      next_addr_latch = cycle_addr_i[2:1]; // [R9]
      next_upper_hit  = control[CTL_UPPER_EN] && (mem_cyc || control[CTL_UPPER_IO]) &&
                        in_range(cycle_addr_i, upper_start, upper_end); // [R10] [R11]
      next_lower_hit  = control[CTL_LOWER_EN] && mem_cyc &&
                        in_range(cycle_addr_i, lower_start, lower_end); // [R11]
      next_coproc_hit = control[CTL_NUMERICS] && cycle_numerics_i; // [R6]
      for (int i = 0; i < NUM_MID; i++) begin
        next_mid_hit[i] = control[CTL_MID_EN] && mem_cyc && !cycle_numerics_i &&
                          in_block(cycle_addr_i, mid_start, mid_span, i); // [R1] [R2]
      end
      for (int i = 0; i < NUM_PERIPH; i++) begin
        next_per_hit[i] = control[CTL_PER_EN] && (cycle_io_i == control[CTL_PER_IO]) &&
                          in_block(cycle_addr_i, per_start, per_span, i); // [R7] [R8]
      end
    end
    if (control[CTL_NUMERICS] && numerics_op_start_i && err_sync[1]) begin
      next_trap = 1'b1; // [R5]
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      active          <= 1'b0;
      upper_hit       <= 1'b0;
      lower_hit       <= 1'b0;
      coproc_hit      <= 1'b0;
      mid_hit         <= '0;
      per_hit         <= '0;
      addr_latch      <= '0;
      numerics_trap_o <= 1'b0;
    end else begin
      active          <= next_active;
      upper_hit       <= next_upper_hit;
      lower_hit       <= next_lower_hit;
      coproc_hit      <= next_coproc_hit;
      mid_hit         <= next_mid_hit;
      per_hit         <= next_per_hit;
      addr_latch      <= next_addr_latch;
      numerics_trap_o <= next_trap;
    end
  end

  // outputs; floated or idle bus forces every select high
  // kept combinational so a grant or powerdown releases the selects at once
  logic quiet;
  assign quiet = bus_granted_i || powerdown_i || !active; // [R12]

  assign upper_region_select_n_o = !(upper_hit && !quiet); // [R12]
  assign lower_region_select_n_o = !(lower_hit && !quiet);
  assign numerics_vector_o       = NUMERICS_VECTOR; // [R5]
  assign coproc_request_o        = control[CTL_NUMERICS] && req_sync[1]; // [R4]

  // pins 0 and 1 become inputs, pin 2 keeps its select, pin 3 the coprocessor select
  always_comb begin
    mid_range_select_oe_o = {NUM_MID{control[CTL_MID_EN]}};
    mid_range_select_n_o  = ~(mid_hit & {NUM_MID{!quiet}});
    if (control[CTL_NUMERICS]) begin // [R3]
      mid_range_select_oe_o[1:0] = 2'h0;
      mid_range_select_oe_o[3]   = 1'b1;
      mid_range_select_n_o[1:0]  = 2'h3;
      mid_range_select_n_o[3]    = !(coproc_hit && !quiet); // [R6]
    end
  end
  assign coproc_select_n_o = !(control[CTL_NUMERICS] && coproc_hit && !quiet); // [R6]

  always_comb begin
    peripheral_select_n_o = ~(per_hit & {NUM_PERIPH{!quiet}});
    if (control[CTL_ADDR_OUT]) begin
      peripheral_select_n_o[NUM_PERIPH-1:NUM_PERIPH_LOW] = {addr_latch[1], addr_latch[0]}; // [R9]
    end
  end

  assign irq_o = |(status & mask);

  a_lower_mem_only: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [R11]
    cycle_start_i && cycle_io_i |=> !lower_hit)
    else $error("lower select hit on io cycle");
  a_select_quiet: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [R12]
    bus_granted_i || powerdown_i |-> upper_region_select_n_o && lower_region_select_n_o &&
      coproc_select_n_o && &mid_range_select_n_o && &peripheral_select_n_o[NUM_PERIPH_LOW-1:0] &&
      (control[CTL_ADDR_OUT] || &peripheral_select_n_o[NUM_PERIPH-1:NUM_PERIPH_LOW]))
    else $error("select active while bus granted or powered down");
  a_trap_pulse: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [R5]
    control[CTL_NUMERICS] && numerics_op_start_i && err_sync[1] |=> numerics_trap_o && status[STS_ERROR])
    else $error("numerics error not trapped");
  a_numerics_pins: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [R3]
    control[CTL_NUMERICS] |-> mid_range_select_oe_o[1:0] == 2'h0 && mid_range_select_oe_o[3])
    else $error("mid pins not handshake in numerics mode");
  a_addr_out: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [R9]
    control[CTL_ADDR_OUT] && cycle_start_i ##1 control[CTL_ADDR_OUT]
      |-> peripheral_select_n_o[NUM_PERIPH-1:NUM_PERIPH_LOW] == $past(cycle_addr_i[2:1]))
    else $error("latched address bits wrong");
  a_hold_cycle: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [R13]
    active && !cycle_end_i && !cycle_start_i |=> $stable(per_hit) && $stable(upper_hit))
    else $error("select changed mid cycle");
  a_mid_disabled: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [R2]
    cycle_start_i && !control[CTL_MID_EN] |=> mid_hit == '0)
    else $error("mid select decoded while disabled");
  a_coproc_sel: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [R6]
    cycle_start_i && cycle_numerics_i && control[CTL_NUMERICS] && !cycle_end_i
      ##1 !bus_granted_i && !powerdown_i |-> !coproc_select_n_o)
    else $error("coprocessor select missing");
  a_upper_io: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [R11]
    cycle_start_i && cycle_io_i && !control[CTL_UPPER_IO] |=> !upper_hit)
    else $error("upper select hit on io cycle while io disabled");
  a_request_seen: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [R4]
    control[CTL_NUMERICS] && req_sync[1] && !req_prev |=> status[STS_REQUEST])
    else $error("coprocessor request not recorded");
  a_per_io_mode: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [R7]
    cycle_start_i && (cycle_io_i != control[CTL_PER_IO]) |=> per_hit == '0)
    else $error("peripheral select on wrong cycle kind");
  a_per_disabled: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [R7]
    cycle_start_i && !control[CTL_PER_EN] |=> per_hit == '0)
    else $error("peripheral select decoded while disabled");
  a_end_release: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [R13]
    cycle_end_i && !cycle_start_i |=> upper_region_select_n_o && lower_region_select_n_o &&
      coproc_select_n_o && &peripheral_select_n_o[NUM_PERIPH_LOW-1:0])
    else $error("select still active after cycle end");
  a_error_sticky: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [R5]
    status[STS_ERROR] && !(reg_write_i && reg_addr_i == REG_STATUS && reg_wdata_i[STS_ERROR])
      |=> status[STS_ERROR])
    else $error("numerics error status lost");
  a_trap_cause: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [R5]
    numerics_trap_o |-> $past(numerics_op_start_i) && $past(err_sync[1]))
    else $error("numerics trap without error at op start");
  a_coproc_idle: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [R6]
    !control[CTL_NUMERICS] |-> coproc_select_n_o && !coproc_request_o)
    else $error("coprocessor pins active outside numerics mode");
  a_lower_idle: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [R10]
    cycle_start_i && !control[CTL_LOWER_EN] |=> lower_region_select_n_o)
    else $error("lower select active while not programmed");
  a_mid2_disabled: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [R2]
    control[CTL_NUMERICS] && !control[CTL_MID_EN] |-> !mid_range_select_oe_o[2])
    else $error("mid pin 2 driven while block disabled");

endmodule : chip_select_unit

// ---- verification/coproc_model.sv ----
`timescale 1ns/1ps
module coproc_model (
  // clock and reset
  input  wire logic ref_clk_i,
  input  wire logic rst_i,
  // bench controls
  input  wire logic want_transfer_i,
  input  wire logic fault_i,
  // pins toward the processor
  input  wire logic coproc_select_n_i,
  output logic      transfer_request_o,
  output logic      error_o
);
  // request holds until the processor selects us, as a real pending transfer would
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      transfer_request_o <= 1'b0;
      error_o            <= 1'b0;
    end else begin
      if (want_transfer_i)
        transfer_request_o <= 1'b1;
      else if (!coproc_select_n_i)
        transfer_request_o <= 1'b0;
      error_o <= fault_i;
    end
  end
endmodule : coproc_model

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  import chip_select_pkg::*;
  logic        ref_clk_i = 1'b0, rst_i = 1'b1, cs = 1'b0, ce = 1'b0, cio = 1'b0, cnum = 1'b0;
  logic        ops = 1'b0, gnt = 1'b0, pd = 1'b0, wr_s = 1'b0, rd_s = 1'b0, want = 1'b0, fault = 1'b0;
  logic [19:0] caddr = 20'h00000, wdata = 20'h00000, rdata, d, e;
  logic [3:0]  raddr = 4'h0, mid_n, mid_oe;
  logic [6:0]  per_n;
  logic [7:0]  vec;
  logic [12:0] s;
  // am: top two peripheral pins carry latched address bits
  logic        up_n, lo_n, csel_n, creq, trap, irq, req_pin, err_pin, c, am = 1'b0;
  int          n_errors = 0, checks_done = 0;
  wire  [12:0] sel_vec = {up_n, lo_n, mid_n, per_n};

  always #5 ref_clk_i = ~ref_clk_i;

  chip_select_unit dut (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .cycle_start_i(cs), .cycle_end_i(ce), .cycle_addr_i(caddr),
    .cycle_io_i(cio), .cycle_numerics_i(cnum), .numerics_op_start_i(ops), .bus_granted_i(gnt),
    .powerdown_i(pd), .reg_addr_i(raddr), .reg_wdata_i(wdata), .reg_write_i(wr_s), .reg_read_i(rd_s),
    .reg_rdata_o(rdata), .coproc_transfer_request_i(req_pin), .coproc_error_i(err_pin),
    .coproc_select_n_o(csel_n), .coproc_request_o(creq), .numerics_trap_o(trap), .numerics_vector_o(vec),
    .upper_region_select_n_o(up_n), .lower_region_select_n_o(lo_n), .mid_range_select_n_o(mid_n),
    .mid_range_select_oe_o(mid_oe), .peripheral_select_n_o(per_n), .irq_o(irq));

  coproc_model partner (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .want_transfer_i(want), .fault_i(fault),
    .coproc_select_n_i(csel_n), .transfer_request_o(req_pin), .error_o(err_pin));

  task automatic check(input string name, input logic [19:0] exp, input logic [19:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic wr(input logic [3:0] a, input logic [19:0] v);
    @(posedge ref_clk_i) begin raddr <= a; wdata <= v; wr_s <= 1'b1; end
    @(posedge ref_clk_i) wr_s <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [19:0] v);
    @(posedge ref_clk_i) begin raddr <= a; rd_s <= 1'b1; end
    @(posedge ref_clk_i) rd_s <= 1'b0;
    #1 v = rdata;
  endtask : rd

  // one bus cycle: selects seen after the start edge, then released after the end edge
  task automatic cyc(input logic [19:0] a, input logic io, input logic num, output logic [12:0] sv,
                     output logic cv);
    @(posedge ref_clk_i) begin caddr <= a; cio <= io; cnum <= num; cs <= 1'b1; end
    @(posedge ref_clk_i) cs <= 1'b0;
    #1 sv = sel_vec;
    cv = csel_n;
    @(posedge ref_clk_i) ce <= 1'b1;
    @(posedge ref_clk_i) ce <= 1'b0;
    #1 check("sel_after_end", {7'h00, 6'h3f, am ? {a[2], a[1]} : 2'h3, 5'h1f}, {7'h00, sel_vec});
  endtask : cyc

  task automatic t_reset;
    check("sel_reset", 20'h01fff, {7'h00, sel_vec});
    check("mid_oe_rst", 20'h00000, {16'h0000, mid_oe});
    rd(REG_CONTROL, d); check("control_rst", 20'h00001, d);
    wr(4'hf, 20'h12345);
    rd(4'hf, d); check("unmapped", 20'h00000, d);
  endtask : t_reset

  task automatic t_upper;
    cyc(20'hffc00, 1'b0, 1'b0, s, c); check("upper_lo_edge", 20'h00fff, {7'h00, s});
    cyc(20'hffbff, 1'b0, 1'b0, s, c); check("upper_below", 20'h01fff, {7'h00, s});
    cyc(20'h00010, 1'b0, 1'b0, s, c); check("lower_rst_off", 20'h01fff, {7'h00, s});
    cyc(20'hfffff, 1'b1, 1'b0, s, c); check("upper_io_off", 20'h01fff, {7'h00, s});
    wr(REG_CONTROL, 20'h00041);
    cyc(20'hfffff, 1'b1, 1'b0, s, c); check("upper_io_on", 20'h00fff, {7'h00, s});
  endtask : t_upper

  task automatic t_lower;
    wr(REG_LOWER_START, 20'h00000);
    wr(REG_LOWER_END, 20'h3ffff);
    wr(REG_CONTROL, 20'h00003);
    cyc(20'h3ffff, 1'b0, 1'b0, s, c); check("lower_mem", 20'h017ff, {7'h00, s});
    cyc(20'h3ffff, 1'b1, 1'b0, s, c); check("lower_io", 20'h01fff, {7'h00, s});
  endtask : t_lower

  task automatic t_mid;
    wr(REG_MID_START, 20'h80000);
    wr(REG_MID_END, 20'h803ff);
    cyc(20'h80000, 1'b0, 1'b0, s, c); check("mid_disabled", 20'h01fff, {7'h00, s});
    wr(REG_CONTROL, 20'h00005);
    check("mid_oe_on", 20'h0000f, {16'h0000, mid_oe});
    for (int k = 0; k < 4; k++) begin
      e = {7'h00, 13'h1fff & ~(13'h0001 << (7 + k))};
      cyc(20'h80000 + 20'(k * 256), 1'b0, 1'b0, s, c); check("mid_block", e, {7'h00, s});
    end
    cyc(20'h80000, 1'b1, 1'b0, s, c); check("mid_io", 20'h01fff, {7'h00, s});
  endtask : t_mid

  task automatic t_per;
    wr(REG_PER_START, 20'h40000);
    wr(REG_PER_END, 20'h4037f);
    wr(REG_CONTROL, 20'h00009);
    for (int k = 0; k < 7; k++) begin
      e = {7'h00, 13'h1fff & ~(13'h0001 << k)};
      cyc(20'h40000 + 20'(k * 128), 1'b0, 1'b0, s, c); check("per_block", e, {7'h00, s});
    end
    wr(REG_CONTROL, 20'h00089);
    cyc(20'h40000, 1'b1, 1'b0, s, c); check("per_io", 20'h01ffe, {7'h00, s});
    wr(REG_CONTROL, 20'h000a9);
    am = 1'b1;
    cyc(20'h40002, 1'b1, 1'b0, s, c); check("per_addr_out", 20'h01fbe, {7'h00, s});
    wr(REG_CONTROL, 20'h00009);
    am = 1'b0;
    @(posedge ref_clk_i) gnt <= 1'b1;
    cyc(20'hffc10, 1'b0, 1'b0, s, c); check("granted", 20'h01fff, {7'h00, s});
    @(posedge ref_clk_i) begin gnt <= 1'b0; pd <= 1'b1; end
    cyc(20'hffc10, 1'b0, 1'b0, s, c); check("powerdown", 20'h01fff, {7'h00, s});
    @(posedge ref_clk_i) pd <= 1'b0;
  endtask : t_per

  task automatic t_num;
    wr(REG_CONTROL, 20'h00015);
    check("mid_oe_num", 20'h0000c, {16'h0000, mid_oe});
    cyc(20'h80200, 1'b0, 1'b0, s, c); check("mid2_in_num", 20'h01dff, {7'h00, s});
    cyc(20'h80000, 1'b0, 1'b0, s, c); check("mid0_in_num", 20'h01fff, {7'h00, s});
    @(posedge ref_clk_i) want <= 1'b1;
    @(posedge ref_clk_i) want <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    #1 check("req_up", 20'h00001, {19'h00000, creq});
    rd(REG_STATUS, d); check("status_req", 20'h00002, d);
    cyc(20'h00100, 1'b0, 1'b1, s, c); check("coproc_sel", 20'h00000, {19'h00000, c});
    check("mid3_is_sel", 20'h00000, {19'h00000, s[10]});
    repeat (4) @(posedge ref_clk_i);
    #1 check("req_down", 20'h00000, {19'h00000, creq});
    @(posedge ref_clk_i) fault <= 1'b1;
    repeat (5) @(posedge ref_clk_i);
    ops <= 1'b1;
    @(posedge ref_clk_i) ops <= 1'b0;
    #1 check("trap", 20'h00001, {19'h00000, trap});
    check("vector", 20'h00010, {12'h000, vec});
    check("irq_masked", 20'h00000, {19'h00000, irq});
    @(posedge ref_clk_i) #1 check("trap_pulse", 20'h00000, {19'h00000, trap});
    wr(REG_MASK, 20'h00001); check("irq_on", 20'h00001, {19'h00000, irq});
    rd(REG_STATUS, d); check("status_err", 20'h00003, d);
    wr(REG_STATUS, 20'h00001); check("irq_clear", 20'h00000, {19'h00000, irq});
    @(posedge ref_clk_i) fault <= 1'b0;
    repeat (5) @(posedge ref_clk_i);
    ops <= 1'b1;
    @(posedge ref_clk_i) ops <= 1'b0;
    #1 check("no_trap", 20'h00000, {19'h00000, trap});
  endtask : t_num

  task automatic end_of_test;
    $display("mismatches %0d comparisons %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test

  initial begin
    repeat (4) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(posedge ref_clk_i) #1;
    t_reset();
    t_upper();
    t_lower();
    t_mid();
    t_per();
    t_num();
    end_of_test();
  end

  // whole run is about two hundred cycles; this leaves ample margin
  initial begin
    #200000;
    n_errors++;
    end_of_test();
  end
endmodule : tb_top
